// ==== rtl/msar_map.vh ====
// constants of the mono amplifier serial audio receiver
// assumes the including file sits on the 10 MHz core clock
`ifndef MSAR_MAP_VH
`define MSAR_MAP_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MSAR_CLK_PERIOD_NS 100
// least quiet time on a link clock before it counts as stopped
`define MSAR_LOSS_TIME_NS 200000
`define MSAR_LOSS_CYCLES ((`MSAR_LOSS_TIME_NS + `MSAR_CLK_PERIOD_NS - 1) / `MSAR_CLK_PERIOD_NS)
// anti-pop power-up sequence, in microseconds
`define MSAR_PWRUP_TIME_US 12660
`define MSAR_PWRUP_CYCLES ((`MSAR_PWRUP_TIME_US * 1000 + `MSAR_CLK_PERIOD_NS - 1) / `MSAR_CLK_PERIOD_NS)

// ----------------------------------------
// frame layout
// ----------------------------------------
`define MSAR_SAMPLE_W 24
`define MSAR_FIFO_DEPTH 8
`define MSAR_LEN_W 9
`define MSAR_RATIO_SHORT 9'h020
`define MSAR_RATIO_SLOT16 9'h080
`define MSAR_RATIO_SLOT32 9'h100
`define MSAR_SLOT_W16 9'h010
`define MSAR_SLOT_W32 9'h020
`define MSAR_BITS_LONG 9'h018
`define MSAR_BITS_SHORT 9'h010
`define MSAR_I2S_MSB_POS 9'h001
`define MSAR_PCM_MSB_POS 9'h000

`endif

// ==== rtl/msar_fifo.v ====
// small synchronous fifo in flip-flops with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`default_nettype none

module msar_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/msar_rx.v ====
// serial audio receiver of a mono amplifier: i2s and pcm time slot slave
// assumes bit clock, frame sync, data and enable arrive asynchronously as pins
//
// Summary of operation
// - slave only: bit clock and frame sync are inputs, never driven
// - data line sampled on rising bit clock edges inside the word window
// - i2s captures a 24-bit msb-first sample for the strapped channel
// - with 32 bit clocks per frame only the 16 msbs are kept
// - i2s msb taken at second rising edge after frame sync change
// - i2s frame sync low is left word, high is right word
// - pcm mode supports eight slots of 16 or 32 bits
// - plain pcm word starts on the frame sync bit, else at the chosen slot
// - i2s or pcm time slot chosen by strap pins
// - stopped frame sync or bit clock shuts the output driver off
// - enable plus running clocks start a 12.66 ms power-up sequence
`include "msar_map.vh"
`default_nettype none

module msar_rx #(
  parameter integer PWRUP_CYCLES = `MSAR_PWRUP_CYCLES
) (
  input wire core_clk,
  input wire sys_rst,
  input wire bit_clk_in,
  input wire frame_sync_in,
  input wire serial_audio_in,
  input wire amp_enable_in,
  input wire fmt_pcm_strap,
  input wire chan_right_strap,
  input wire [2:0] slot_strap,
  output reg [23:0] sample_data_q,
  output reg sample_valid_q,
  input wire sample_ready,
  output reg driver_on_q,
  output reg clocks_ok_q,
  output reg overrun_q
);

  // ----------------------------------------
  // constants and helpers
  // ----------------------------------------
  localparam integer LOSS_CYC = `MSAR_LOSS_CYCLES;
  localparam [10:0] LOSS_LAST = LOSS_CYC[10:0] - 11'h001;
  localparam [16:0] PWR_LAST = PWRUP_CYCLES[16:0] - 17'h00001;
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_RAMP = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  function in_window;
    input [8:0] pos;
    input [8:0] start;
    input [8:0] len;
    begin
      in_window = (pos >= start) && (pos < start + len);
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // link pins inputs only
  wire [3:0] pin_raw = {amp_enable_in, serial_audio_in, frame_sync_in, bit_clk_in};
  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;
  reg [3:0] pin_s3_q;
  reg [3:0] pin_flt_q;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      // a change counts only once stages two and three agree
      always @(posedge core_clk) begin
        if (sys_rst) begin
          pin_s1_q[g] <= 1'b0;
          pin_s2_q[g] <= 1'b0;
          pin_s3_q[g] <= 1'b0;
          pin_flt_q[g] <= 1'b0;
        end else begin
          pin_s1_q[g] <= pin_raw[g];
          pin_s2_q[g] <= pin_s1_q[g];
          pin_s3_q[g] <= pin_s2_q[g];
          if (pin_s2_q[g] == pin_s3_q[g]) begin
            pin_flt_q[g] <= pin_s3_q[g];
          end
        end
      end
    end
  endgenerate

  wire bclk_lvl = pin_flt_q[0];
  wire fs_lvl = pin_flt_q[1];
  wire data_lvl = pin_flt_q[2];
  wire en_lvl = pin_flt_q[3];

  // ----------------------------------------
  // straps, caught once after reset release
  // ----------------------------------------
  reg strap_done_q;
  reg pcm_mode_q;
  reg chan_right_q;
  reg [2:0] slot_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      pcm_mode_q <= 1'b0;
      chan_right_q <= 1'b0;
      slot_q <= 3'h0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      pcm_mode_q <= fmt_pcm_strap;
      chan_right_q <= chan_right_strap;
      slot_q <= slot_strap;
    end
  end

  // ----------------------------------------
  // bit clock edges and frame position
  // ----------------------------------------
  reg bclk_prev_q;
  reg fs_prev_q;
  reg [8:0] bit_pos_q;
  reg [8:0] per_cnt_q;
  reg [8:0] frame_len_q;
  reg [23:0] shift_q;
  reg word_pend_q;
  reg [23:0] word_q;

  wire bclk_rise = bclk_lvl & ~bclk_prev_q;
  wire fs_change = bclk_rise & (fs_lvl != fs_prev_q);
  wire fs_rise = fs_change & fs_lvl;
  // count restarts at any i2s sync change, only at sync rise in pcm
  wire pos_restart = pcm_mode_q ? fs_rise : fs_change;
  wire [8:0] pos_now = pos_restart ? 9'h000 : bit_pos_q;

  wire i2s_short = (frame_len_q == `MSAR_RATIO_SHORT);
  wire [8:0] i2s_bits = i2s_short ? `MSAR_BITS_SHORT : `MSAR_BITS_LONG;
  // slot width from bit clocks per frame
  wire slot32 = (frame_len_q == `MSAR_RATIO_SLOT32);
  wire pcm_len_ok = slot32 | (frame_len_q == `MSAR_RATIO_SLOT16);
  wire [8:0] slot_w = slot32 ? `MSAR_SLOT_W32 : `MSAR_SLOT_W16;
  wire [8:0] pcm_bits = slot32 ? `MSAR_BITS_LONG : `MSAR_BITS_SHORT;
  // slot start is index times width
  wire [8:0] slot_start = slot32 ? {1'b0, slot_q, 5'h00} : {2'b00, slot_q, 4'h0};
  // low sync is left, high is right
  wire chan_match = (fs_lvl == chan_right_q);
  wire [8:0] i2s_start = `MSAR_I2S_MSB_POS;
  wire [8:0] pcm_start = `MSAR_PCM_MSB_POS + slot_start;
  wire [8:0] word_bits = pcm_mode_q ? pcm_bits : i2s_bits;
  // short frames: the lsb lands on the first edge after the sync flips
  wire i2s_tail = i2s_short & pos_restart & (fs_prev_q == chan_right_q) & (bit_pos_q == `MSAR_BITS_SHORT);
  wire i2s_last = i2s_short ? i2s_tail : (pos_now == i2s_start + i2s_bits - 9'h001);
  wire take_bit = bclk_rise & strap_done_q &
                  (pcm_mode_q ? (pcm_len_ok & in_window(pos_now, pcm_start, pcm_bits))
                              : ((chan_match & in_window(pos_now, i2s_start, i2s_bits)) | i2s_tail));
  wire last_bit = take_bit & (pcm_mode_q ? (pos_now == pcm_start + pcm_bits - 9'h001) : i2s_last);
  wire [23:0] shift_d = {shift_q[22:0], data_lvl};
  wire short_word = (word_bits == `MSAR_BITS_SHORT);
  wire [23:0] word_d = short_word ? {shift_d[15:0], 8'h00} : shift_d;

  wire fifo_in_ready;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      bclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      bit_pos_q <= 9'h1ff;
      per_cnt_q <= 9'h000;
      frame_len_q <= 9'h000;
      shift_q <= 24'h000000;
      word_pend_q <= 1'b0;
      word_q <= 24'h000000;
      overrun_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_lvl;
      if (bclk_rise) begin
        fs_prev_q <= fs_lvl;
        bit_pos_q <= (pos_now == 9'h1ff) ? pos_now : pos_now + 9'h001;
        if (fs_rise) begin
          frame_len_q <= per_cnt_q + 9'h001;
          per_cnt_q <= 9'h000;
        end else if (per_cnt_q != 9'h1ff) begin
          per_cnt_q <= per_cnt_q + 9'h001;
        end
      end
      if (take_bit) begin
        shift_q <= shift_d;
      end
      // a full fifo holds the word back; a newer word meanwhile overwrites it and the held word is lost
      if (last_bit) begin
        word_q <= word_d;
        word_pend_q <= 1'b1;
        if (word_pend_q & ~fifo_in_ready) begin
          overrun_q <= 1'b1;
        end
      end else if (fifo_in_ready) begin
        word_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sample buffer and registered output
  // ----------------------------------------
  wire fifo_out_valid;
  wire [23:0] fifo_out_data;
  wire out_load = ~sample_valid_q | sample_ready;

  msar_fifo #(
    .WIDTH(`MSAR_SAMPLE_W),
    .DEPTH(`MSAR_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(core_clk),
    .rst(sys_rst),
    .in_valid(word_pend_q),
    .in_ready(fifo_in_ready),
    .in_data(word_q),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data)
  );

  always @(posedge core_clk) begin
    if (sys_rst) begin
      sample_valid_q <= 1'b0;
      sample_data_q <= 24'h000000;
    end else if (out_load) begin
      sample_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        sample_data_q <= fifo_out_data;
      end
    end
  end

  // ----------------------------------------
  // clock watchdog and power sequencing
  // ----------------------------------------
  reg [10:0] bclk_idle_q;
  reg [10:0] fs_idle_q;
  reg [1:0] pwr_st_q;
  reg [16:0] pwr_cnt_q;
  wire fs_edge_raw = fs_lvl ^ fs_prev_q;
  wire bclk_dead = (bclk_idle_q == LOSS_LAST);
  wire fs_dead = (fs_idle_q == LOSS_LAST);
  wire clocks_run = ~bclk_dead & ~fs_dead;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      bclk_idle_q <= LOSS_LAST;
      fs_idle_q <= LOSS_LAST;
    end else begin
      bclk_idle_q <= bclk_rise ? 11'h000 : (bclk_dead ? bclk_idle_q : bclk_idle_q + 11'h001);
      fs_idle_q <= (bclk_rise & fs_edge_raw) ? 11'h000 : (fs_dead ? fs_idle_q : fs_idle_q + 11'h001);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_st_q <= ST_OFF;
      pwr_cnt_q <= 17'h00000;
      driver_on_q <= 1'b0;
      clocks_ok_q <= 1'b0;
    end else begin
      clocks_ok_q <= clocks_run;
      case (pwr_st_q)
        ST_OFF: begin
          driver_on_q <= 1'b0;
          pwr_cnt_q <= 17'h00000;
          // enable and clocks start the ramp
          if (en_lvl & clocks_run) begin
            pwr_st_q <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (~en_lvl | ~clocks_run) begin
            pwr_st_q <= ST_OFF;
          end else if (pwr_cnt_q == PWR_LAST) begin
            pwr_st_q <= ST_RUN;
            driver_on_q <= 1'b1;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + 17'h00001;
          end
        end
        ST_RUN: begin
          if (~en_lvl | ~clocks_run) begin
            pwr_st_q <= ST_OFF;
            driver_on_q <= 1'b0;
          end
        end
        default: begin
          pwr_st_q <= ST_OFF;
          driver_on_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== dv/msar_rx_properties.sv ====
// port assertions for the serial audio receiver
// assumes a bind onto msar_rx, everything on core_clk
`default_nettype none
module msar_rx_chk #(parameter integer PWRUP_CYCLES = 200) (
  input wire core_clk,
  input wire sys_rst,
  input wire bit_clk_in,
  input wire frame_sync_in,
  input wire serial_audio_in,
  input wire amp_enable_in,
  input wire fmt_pcm_strap,
  input wire chan_right_strap,
  input wire [2:0] slot_strap,
  input wire [23:0] sample_data_q,
  input wire sample_valid_q,
  input wire sample_ready,
  input wire driver_on_q,
  input wire clocks_ok_q,
  input wire overrun_q
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic bclk_q;
  logic [11:0] idle_q;
  logic [31:0] ok_q;
  // quiet time counted from the last pin change; design counts from the last rise
  always @(posedge core_clk) begin
    bclk_q <= bit_clk_in;
    if (sys_rst || bit_clk_in != bclk_q) idle_q <= 12'h000;
    else if (idle_q != 12'hfff) idle_q <= idle_q + 12'h001;
    if (sys_rst || !clocks_ok_q || !amp_enable_in) ok_q <= 32'h0;
    else if (ok_q < PWRUP_CYCLES) ok_q <= ok_q + 32'h1;
  end
  sequence stall_s; sample_valid_q && !sample_ready; endsequence
  sequence en_low_s; !amp_enable_in [*8]; endsequence
  reset_out_a: assert property ($fell(sys_rst) |-> !sample_valid_q && !driver_on_q && !overrun_q)
    else $error("outputs not clear after reset");
  valid_hold_a: assert property (stall_s |=> sample_valid_q && $stable(sample_data_q))
    else $error("sample dropped while stalled");
  overrun_why_a: assert property ($rose(overrun_q) |-> $past(sample_valid_q) && !$past(sample_ready))
    else $error("overrun without stall");
  overrun_keep_a: assert property (overrun_q |=> overrun_q)
    else $error("overrun flag cleared");
  drv_enable_a: assert property (en_low_s |-> !driver_on_q)
    else $error("driver on with enable low");
  drv_clocks_a: assert property (!clocks_ok_q |=> !driver_on_q)
    else $error("driver on without clocks");
  clk_stop_a: assert property (idle_q >= 2020 |-> !clocks_ok_q && !driver_on_q)
    else $error("stopped clock not detected");
  pwrup_time_a: assert property ($rose(driver_on_q) |-> ok_q >= PWRUP_CYCLES)
    else $error("driver on before power-up ends");
endmodule
bind msar_rx msar_rx_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .bit_clk_in(bit_clk_in), .frame_sync_in(frame_sync_in), .serial_audio_in(serial_audio_in),
  .amp_enable_in(amp_enable_in), .fmt_pcm_strap(fmt_pcm_strap), .chan_right_strap(chan_right_strap),
  .slot_strap(slot_strap), .sample_data_q(sample_data_q), .sample_valid_q(sample_valid_q),
  .sample_ready(sample_ready), .driver_on_q(driver_on_q), .clocks_ok_q(clocks_ok_q), .overrun_q(overrun_q));
`default_nettype wire

// ==== dv/msar_host_model.sv ====
// audio host model: makes bit clock, frame sync and data, 800 ns bit period
// assumes the caller runs one frame at a time; the clock stands still between
`default_nettype none
module msar_host_model (
  output logic bit_clk_in,
  output logic frame_sync_in,
  output logic serial_audio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] carry_q = 32'h0;
  initial begin
    bit_clk_in = 1'b0;
    frame_sync_in = 1'b1;
    serial_audio_in = 1'b0;
  end
  // one lead-in edge so the receiver learns the idle sync level before frame 0
  task automatic prime(input logic lvl);
    frame_sync_in = lvl;
    #400 bit_clk_in = 1'b1;
    #400 bit_clk_in = 1'b0;
  endtask
  // host makes both clocks, data moves on falling edges
  task automatic send_frame(input logic pcm, input int n, input int slot, input logic [23:0] a, input logic [23:0] b);
    int half, w, p;
    logic [31:0] sa, sb, cur;
    half = n / 2;
    w = n / 8;
    sa = {a, 8'h00};
    sb = {b, 8'h00};
    for (int k = 0; k < n; k++) begin
      if (pcm) begin
        // one sync bit, word only in the chosen slot, toggling filler elsewhere
        frame_sync_in = (k == 0);
        p = k - slot * w;
        serial_audio_in = (p >= 0 && p < w) ? sa[31 - p] : ~serial_audio_in;
      end else begin
        // sync low left, msb one bit late; short frames spill the lsb over
        frame_sync_in = (k >= half);
        p = k % half;
        cur = (k >= half) ? sb : sa;
        if (p == 0 && n == 32) serial_audio_in = (k >= half) ? sa[16] : carry_q[16];
        else serial_audio_in = (p >= 1 && p <= 24) ? cur[32 - p] : ~serial_audio_in;
      end
      #400 bit_clk_in = 1'b1;
      #400 bit_clk_in = 1'b0;
    end
    carry_q = sb;
    serial_audio_in = ~serial_audio_in;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench of the serial audio receiver
// assumes the host model drives the link; sink and straps driven here
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, amp_enable_in = 1'b0;
  logic fmt_pcm_strap = 1'b0, chan_right_strap = 1'b0, sample_ready = 1'b1;
  logic [2:0] slot_strap = 3'h0;
  wire bit_clk_in, frame_sync_in, serial_audio_in, sample_valid_q, driver_on_q, clocks_ok_q, overrun_q;
  wire [23:0] sample_data_q;
  logic [23:0] got[$];
  int bad_count = 0;
  int total_checks = 0;
  always #50 core_clk = ~core_clk;
  msar_rx #(.PWRUP_CYCLES(200)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bit_clk_in(bit_clk_in),
    .frame_sync_in(frame_sync_in), .serial_audio_in(serial_audio_in), .amp_enable_in(amp_enable_in),
    .fmt_pcm_strap(fmt_pcm_strap), .chan_right_strap(chan_right_strap), .slot_strap(slot_strap),
    .sample_data_q(sample_data_q), .sample_valid_q(sample_valid_q), .sample_ready(sample_ready),
    .driver_on_q(driver_on_q), .clocks_ok_q(clocks_ok_q), .overrun_q(overrun_q));
  msar_host_model i_host (.bit_clk_in(bit_clk_in), .frame_sync_in(frame_sync_in),
    .serial_audio_in(serial_audio_in));
  always @(posedge core_clk) if (sample_valid_q === 1'b1 && sample_ready === 1'b1) got.push_back(sample_data_q);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [23:0] word(input int ch, input int f);
    return (ch ? 24'hc3a5e1 : 24'h5a3c96) ^ 24'(f * 'h10101);
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic restart(input logic pcm, input logic right, input logic [2:0] slot, input logic en);
    idle(1);
    sys_rst = 1'b1;
    fmt_pcm_strap = pcm;
    chan_right_strap = right;
    slot_strap = slot;
    amp_enable_in = en;
    idle(2);
    sys_rst = 1'b0;
    got.delete();
  endtask
  task automatic run(input logic pcm, input int n, input int slot, input int frames);
    i_host.prime(~pcm);
    for (int f = 0; f < frames; f++) i_host.send_frame(pcm, n, slot, word(0, f), word(1, f));
    idle(30);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_i2s_channels;
    for (int ch = 0; ch < 2; ch++) begin
      restart(1'b0, ch[0], 3'h0, 1'b0);
      run(1'b0, 64, 0, 3);
      check(24'(got.size()), 24'h3);
      for (int i = 0; i < 3; i++) check(got[i], word(ch, i));
    end
  endtask
  task automatic t_i2s_short;
    logic [23:0] w;
    restart(1'b0, 1'b0, 3'h0, 1'b0);
    run(1'b0, 32, 0, 3);
    w = word(0, 2);
    check(got[$], {w[23:8], 8'h00});
  endtask
  task automatic t_overrun;
    restart(1'b0, 1'b0, 3'h0, 1'b0);
    sample_ready = 1'b0;
    run(1'b0, 64, 0, 12);
    check({23'h0, overrun_q}, 24'h1);
    sample_ready = 1'b1;
    idle(30);
    check(24'(got.size()), 24'ha);
    for (int i = 0; i < 9; i++) check(got[i], word(0, i));
    check(got[9], word(0, 11));
  endtask
  task automatic t_power;
    restart(1'b0, 1'b0, 3'h0, 1'b1);
    run(1'b0, 64, 0, 2);
    check({22'h0, driver_on_q, clocks_ok_q}, 24'h3);
    amp_enable_in = 1'b0;
    idle(10);
    check({23'h0, driver_on_q}, 24'h0);
    amp_enable_in = 1'b1;
    run(1'b0, 64, 0, 1);
    check({23'h0, driver_on_q}, 24'h1);
    idle(2100);
    check({22'h0, driver_on_q, clocks_ok_q}, 24'h0);
  endtask
  task automatic t_pcm_slots;
    int slots[4] = '{0, 3, 7, 5};
    int lens[4] = '{128, 128, 256, 256};
    logic [23:0] w;
    for (int i = 0; i < 4; i++) begin
      restart(1'b1, 1'b0, 3'(slots[i]), 1'b0);
      run(1'b1, lens[i], slots[i], 3);
      w = word(0, 2);
      check(got[$], lens[i] == 128 ? {w[23:8], 8'h00} : w);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #6000000;
    bad_count++;
    $display("ERROR %0t ns: watchdog expired", $time);
    final_report();
  end
  initial begin
    t_i2s_channels();
    t_i2s_short();
    t_overrun();
    t_power();
    t_pcm_slots();
    final_report();
  end
endmodule
`default_nettype wire
